// ---- sbrg_defs.vh ----
// Purpose: Constants for the serial rate divider block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Register values are 8 bits wide and sit in the low byte.
`ifndef SBRG_DEFS_VH
`define SBRG_DEFS_VH
`define SBRG_OFS_TXCTL 12'h000
`define SBRG_OFS_RXCTL 12'h004
`define SBRG_OFS_RATECTL 12'h008
`define SBRG_OFS_DIVHI 12'h00C
`define SBRG_OFS_DIVLO 12'h010
`define SBRG_OFS_STATUS 12'h014
`define SBRG_BIT_SYNC 4
`define SBRG_BIT_HSPEED 2
`define SBRG_BIT_TXIDLE 1
`define SBRG_BIT_SERIAL_PORT_ENABLE 7
`define SBRG_BIT_WIDE 3
`define SBRG_BIT_RXIDLE 6
`define SBRG_RST_TXCTL 8'h02
`define SBRG_RST_RXCTL 8'h00
`define SBRG_RST_RATECTL 8'h40
`define SBRG_RST_DIV 8'h00
`define SBRG_TXCTL_WMASK 8'hFD
`define SBRG_RXCTL_WMASK 8'hF8
`define SBRG_RATECTL_WMASK 8'h1B
`define SBRG_PRE_LOW 6'h3F
`define SBRG_PRE_HIGH 6'h0F
`define SBRG_PRE_SYNC 6'h03
`define SBRG_SAMPLES 3
`endif

// ---- sbrg_rate_assertions.sv ----
// Purpose: Port checks for the rate divider.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every divider instance.
`timescale 1ns/1ps
`default_nettype none
module sbrg_rate_assertions (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic bitTick,
    input wire logic rateTick,
    input wire logic portEnable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Two-step bus transfer
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_ready_one_wait: assert property (s_setup ##1 s_access |=> pready) else $error("ready late");
    a_ready_in_access: assert property (pready |-> s_access) else $error("ready outside access");
    a_ready_one_pulse: assert property (pready |=> !pready) else $error("ready held");
    a_err_unmapped: assert property (pready && paddr > 12'h014 |-> pslverr) else $error("no error");
    a_err_mapped: assert property (pready && !pwrite && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("bad error");
    a_bit_spacing: assert property (bitTick |=> !bitTick [*3]) else $error("bit ticks close");
    a_rate_spacing: assert property (rateTick |=> !rateTick [*3]) else $error("rate ticks close");
    a_off_quiet: assert property (!portEnable && !$past(portEnable) |-> !bitTick && !rateTick) else $error("tick off");
endmodule // sbrg_rate_assertions
bind sbrg_rate_gen sbrg_rate_assertions i_chk (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .bitTick(bitTick),
    .rateTick(rateTick), .portEnable(portEnable));
`default_nettype wire

// ---- sbrg_rate_gen.v ----
// Purpose: Rate divider with APB registers and receive pin majority vote.
// Assumes: One 50 MHz clock; rx pin is asynchronous and synchronised here.
// Notes: Bit ticks drive the port's shift logic outside this block.
`include "sbrg_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module sbrg_rate_gen (
    input wire clk,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire rxPin,
    input wire txShiftEmpty,
    input wire rxIdle,
    output reg rateTick,
    output reg bitTick,
    output reg sampleTick,
    output reg rxBit,
    output reg portEnable
);
    reg [7:0] txCtl_r;
    reg [7:0] rxCtl_r;
    reg [7:0] rateCtl_r;
    reg [7:0] divHi_r;
    reg [7:0] divLo_r;
    reg [15:0] divCnt_r;
    reg [15:0] divCnt_nxt;
    reg [5:0] preCnt_r;
    reg [5:0] preCnt_nxt;
    reg [5:0] preMax;
    reg [15:0] divisor;
    reg divWrite_r;
    reg rxMeta_r;
    reg rxSync_r;
    reg [`SBRG_SAMPLES-1:0] samples_r;
    reg [1:0] sampleIdx_r;
    reg [31:0] rdData;
    reg rdHit;
    wire access;
    wire wrAccess;
    wire serial_port_enable;
    wire syncMode;
    wire wideMode;
    wire hiSpeed;
    wire preWrap;
    wire divWrap;

    // Decode a word address into a mapped flag
    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `SBRG_OFS_TXCTL) || (a == `SBRG_OFS_RXCTL) || (a == `SBRG_OFS_RATECTL) ||
                     (a == `SBRG_OFS_DIVHI) || (a == `SBRG_OFS_DIVLO) || (a == `SBRG_OFS_STATUS);
        end
    endfunction

    assign access = psel && penable && pready;
    assign wrAccess = access && pwrite && mapped(paddr);
    assign serial_port_enable = rxCtl_r[`SBRG_BIT_SERIAL_PORT_ENABLE];
    assign syncMode = txCtl_r[`SBRG_BIT_SYNC];
    assign wideMode = rateCtl_r[`SBRG_BIT_WIDE];
    assign hiSpeed = txCtl_r[`SBRG_BIT_HSPEED];

    // APB: one wait state, answer in access phase second cycle
    always @(posedge clk) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped(paddr);
            if (psel && penable && !pready) begin
                prdata <= (pwrite || !rdHit) ? 32'h00000000 : rdData;
            end
        end
    end

    // Read mux; reserved bits read as zero
    always @* begin
        rdData = 32'h00000000;
        rdHit = 1'b1;
        case (paddr)
            `SBRG_OFS_TXCTL: begin
                rdData[7:0] = {txCtl_r[7:2], txShiftEmpty, txCtl_r[0]};
            end
            `SBRG_OFS_RXCTL: begin
                rdData[7:0] = rxCtl_r;
            end
            `SBRG_OFS_RATECTL: begin
                rdData[7:0] = {rateCtl_r[7], rxIdle, rateCtl_r[5:0]};
            end
            `SBRG_OFS_DIVHI: begin
                rdData[7:0] = divHi_r;
            end
            `SBRG_OFS_DIVLO: begin
                rdData[7:0] = divLo_r;
            end
            `SBRG_OFS_STATUS: begin
                rdData[7:0] = {5'h00, rxBit, bitTick, portEnable};
            end
            default: begin
                rdHit = 1'b0;
            end
        endcase
    end

    // Register writes take effect at the completing edge
    always @(posedge clk) begin
        if (!rstn) begin
            txCtl_r <= `SBRG_RST_TXCTL;
            rxCtl_r <= `SBRG_RST_RXCTL;
            rateCtl_r <= `SBRG_RST_RATECTL;
            divHi_r <= `SBRG_RST_DIV;
            divLo_r <= `SBRG_RST_DIV;
            divWrite_r <= 1'b0;
        end else begin
            divWrite_r <= 1'b0;
            if (wrAccess) begin
                case (paddr)
                    `SBRG_OFS_TXCTL: txCtl_r <= pwdata[7:0] & `SBRG_TXCTL_WMASK;
                    `SBRG_OFS_RXCTL: rxCtl_r <= pwdata[7:0] & `SBRG_RXCTL_WMASK;
                    `SBRG_OFS_RATECTL: rateCtl_r <= pwdata[7:0] & `SBRG_RATECTL_WMASK;
                    `SBRG_OFS_DIVHI: begin
                        divHi_r <= pwdata[7:0];
                        divWrite_r <= 1'b1;
                    end
                    `SBRG_OFS_DIVLO: begin
                        divLo_r <= pwdata[7:0];
                        divWrite_r <= 1'b1;
                    end
                    default: begin
                        divWrite_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Prescale and divisor selection by mode
    always @* begin
        divisor = wideMode ? {divHi_r, divLo_r} : {8'h00, divLo_r};
        if (syncMode) begin
            preMax = `SBRG_PRE_SYNC;
        end else if (!wideMode && !hiSpeed) begin
            preMax = `SBRG_PRE_LOW;
        end else if (wideMode && hiSpeed) begin
            preMax = `SBRG_PRE_SYNC;
        end else begin
            preMax = `SBRG_PRE_HIGH;
        end
    end

    assign preWrap = (preCnt_r >= preMax);
    assign divWrap = (divCnt_r >= divisor);

    // Next counter values; system clock is the only time base
    always @* begin
        preCnt_nxt = preWrap ? 6'h00 : preCnt_r + 6'h01;
        divCnt_nxt = divCnt_r;
        if (preWrap) begin
            divCnt_nxt = divWrap ? 16'h0000 : divCnt_r + 16'h0001;
        end
    end

    // Divider counters, held while port disabled or restarted by a divisor write
    always @(posedge clk) begin
        if (!rstn || !serial_port_enable || divWrite_r) begin
            preCnt_r <= 6'h00;
            divCnt_r <= 16'h0000;
            rateTick <= 1'b0;
            bitTick <= 1'b0;
            sampleIdx_r <= 2'h0;
        end else begin
            preCnt_r <= preCnt_nxt;
            divCnt_r <= divCnt_nxt;
            rateTick <= preWrap;
            bitTick <= preWrap && divWrap;
            if (preWrap && divWrap) begin
                sampleIdx_r <= 2'h0;
            end else if (preWrap && sampleIdx_r != 2'h3) begin
                sampleIdx_r <= sampleIdx_r + 2'h1;
            end
        end
    end

    // Receive pin synchroniser
    always @(posedge clk) begin
        if (!rstn) begin
            rxMeta_r <= 1'b1;
            rxSync_r <= 1'b1;
        end else begin
            rxMeta_r <= rxPin;
            rxSync_r <= rxMeta_r;
        end
    end

    // Three samples on the first sub-ticks of each bit, then vote
    always @(posedge clk) begin
        if (!rstn || !serial_port_enable) begin
            samples_r <= 3'h7;
            rxBit <= 1'b1;
            sampleTick <= 1'b0;
            portEnable <= 1'b0;
        end else begin
            portEnable <= 1'b1;
            sampleTick <= preWrap && (sampleIdx_r < 2'h3) && !divWrite_r;
            if (preWrap && sampleIdx_r < 2'h3 && !divWrite_r) begin
                samples_r <= {samples_r[1:0], rxSync_r};
            end
            rxBit <= (samples_r[0] & samples_r[1]) | (samples_r[0] & samples_r[2]) |
                     (samples_r[1] & samples_r[2]);
        end
    end
endmodule // sbrg_rate_gen
`default_nettype wire

// ---- sbrg_rate_gen_bench.sv ----
// Purpose: Self-checking bench for the rate divider.
// Assumes: Bus master drives on rising edges by non-blocking assignment.
// Notes: Rows hold control, rate, high and low bytes; periods derived here.
`timescale 1ns/1ps
`default_nettype none
module sbrg_rate_gen_bench;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rxLevel = 1'b1, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, r;
    logic [31:0] rows [6] = '{32'h00000001, 32'h04000002, 32'h00080100, 32'h04080003, 32'h14000500, 32'h10080007};
    wire [31:0] prdata;
    wire pready, pslverr, rxPin, txShiftEmpty, rxIdle, rateTick, bitTick, sampleTick, rxBit, portEnable;
    int err_total = 0, compares = 0, g, i, p;
    always #10 clk = ~clk;
    sbrg_rate_gen i_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxPin(rxPin),
        .txShiftEmpty(txShiftEmpty), .rxIdle(rxIdle), .rateTick(rateTick), .bitTick(bitTick),
        .sampleTick(sampleTick), .rxBit(rxBit), .portEnable(portEnable));
    sbrg_shift_model i_far (.clk(clk), .rstn(rstn), .bitTick(bitTick), .rxLevel(rxLevel), .rxPin(rxPin),
        .txShiftEmpty(txShiftEmpty), .rxIdle(rxIdle));
    // Compare one value
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Verdict and end of run
    task close_out;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Bus transfer, waits for ready under a bound
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        for (g = 0; g < 50 && pready !== 1'b1; g++) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (g >= 50) begin
            err_total++;
            $display("mismatch %0t bus wait ran out", $time);
            close_out;
        end
    endtask
    // Clocks up to the next bit tick
    task wait_tick;
        g = 0;
        do @(posedge clk); while (bitTick !== 1'b1 && ++g < 9000);
        g++;
        if (g >= 9000) begin
            err_total++;
            $display("mismatch %0t tick wait ran out", $time);
            close_out;
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        for (i = 0; i < 5; i++) begin
            apb(0, 12'(i * 4), 8'h00);
            chk(rd, {24'h0, i == 0 ? 8'h02 : i == 2 ? 8'h40 : 8'h00}, "reset value");
        end
        apb(0, 12'h018, 8'h00);
        chk({er, rd[30:0]}, 32'h80000000, "unmapped");
        apb(1, 12'h008, 8'hFF);
        apb(0, 12'h008, 8'h00);
        chk(rd, 32'h5B, "rate mask");
        $display("test registers done");
        for (i = 0; i < 6; i++) begin
            r = rows[i];
            apb(1, 12'h004, 8'h00);
            apb(1, 12'h000, r[31:24]);
            apb(1, 12'h008, r[23:16]);
            apb(1, 12'h00C, r[15:8]);
            apb(1, 12'h010, r[7:0]);
            apb(1, 12'h004, 8'h80);
            p = r[28] || (r[19] && r[26]) ? 4 : r[19] || r[26] ? 16 : 64;
            p = p * ((r[19] ? int'(r[15:0]) : int'(r[7:0])) + 1);
            wait_tick;
            wait_tick;
            chk(32'(g), 32'(p), "period");
        end
        $display("test periods done");
        apb(1, 12'h010, 8'hFF);
        wait_tick;
        repeat (100) @(posedge clk);
        apb(1, 12'h010, 8'h40);
        wait_tick;
        chk(32'(g >= 260 && g <= 264), 32'h1, "restart");
        $display("test restart done");
        apb(1, 12'h010, 8'h03);
        for (i = 0; i < 2; i++) begin
            rxLevel <= 1'(i);
            repeat (3) wait_tick;
            chk({31'h0, rxBit}, 32'(i), "majority");
        end
        $display("test sampling done");
        apb(1, 12'h004, 8'h00);
        repeat (2) @(posedge clk);
        p = 0;
        repeat (200) @(posedge clk) p += int'(bitTick !== 1'b0 || portEnable !== 1'b0);
        chk(32'(p), 32'h0, "disabled");
        $display("test disable done");
        close_out;
    end
endmodule // sbrg_rate_gen_bench
`default_nettype wire

// ---- sbrg_shift_model.sv ----
// Purpose: Shift logic stand-in on the far side of the divider.
// Assumes: Line level comes from the bench.
// Notes: Transmit status flips on each bit tick.
`timescale 1ns/1ps
`default_nettype none
module sbrg_shift_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic bitTick,
    input wire logic rxLevel,
    output logic rxPin = 1'b1,
    output logic txShiftEmpty = 1'b1,
    output logic rxIdle = 1'b1
);
    // Line follows the bench, idle while high, empty flag toggles per bit
    always @(posedge clk) begin
        rxPin <= rxLevel;
        rxIdle <= rxLevel;
        txShiftEmpty <= !rstn ? 1'b1 : txShiftEmpty ^ bitTick;
    end
endmodule // sbrg_shift_model
`default_nettype wire
